/* bench/eomctl_pullup.sv */
// far-side pull-up resistor on the open-drain status pin
// assumes oe_n low means the device pulls the pin low
`timescale 1ns/1ps
module eomctl_pullup (
  input  wire logic oe_n_i, // low while device pulls pin
  output logic      pin_o   // resolved pin level
);
  // released pin floats up to the logic supply, never holds a stale low
  assign pin_o = oe_n_i ? 1'b1 : 1'b0;
endmodule

/* bench/eomctl_top_tb.sv */
// self-checking bench for eomctl_top: straps, drive overrides, function, status pin
// assumes eomctl_pullup resolves the status pin; eye sampler inputs are driven only during the eye sweep scenario
`timescale 1ns/1ps
module eomctl_top_tb;
  import eomctl_pkg::*;
  logic       clk_i    = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       lock     = 1'b0;
  logic       los0     = 1'b0;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic       cd       = 1'b0;
  logic       rgt      = 1'b1;  // video rate above 3 Gbps, level R clock output at 297 MHz
  logic       rok      = 1'b1;  // rate high enough for eye captures
  logic       bit_on   = 1'b0;  // eye sampler bit strobe
  logic       hit      = 1'b0;  // eye sampler hit, odd voltage rows
  logic [5:0] ph, vo;
  logic [2:0] fs       = 3'h3;  // function strap at level F
  logic [2:0] ds       = 3'h7;  // drive strap at level H
  logic [7:0] addr     = 8'h00;
  logic [7:0] wd       = 8'h00;
  logic [7:0] rdata;
  logic [2:0] s0, d0, s1, d1;
  logic       e0, c0, e1, c1, cs, cv, oe_n, pin, spo;
  int         err_total    = 0;
  int         total_checks = 0;
  // ******************************************************
  // clock, design and pin
  // ******************************************************
  always #20 clk_i = ~clk_i;
  eomctl_top u_eomctl_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
    .func_strap_i(fs), .drv_strap_i(ds), .cdr_lock_i(lock), .cd0_i(cd), .cd1_i(cd),
    .adapt_done_i(cd), .los0_i(los0), .los1_i(cd), .rate_eom_ok_i(rok),
    .rate_gt_3g_i(rgt), .eom_bit_i(bit_on), .eom_hit_i(hit), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .eom_phase_o(ph), .eom_volt_o(vo), .output_port_zero_eq_en_o(e0), .output_port_zero_cdr_en_o(c0),
    .output_port_one_eq_en_o(e1), .output_port_one_cdr_en_o(c1), .output_port_one_clk_sel_o(cs), .output_port_one_clk_div_o(cv),
    .output_port_zero_swing_o(s0), .output_port_zero_deemph_o(d0), .output_port_one_swing_o(s1), .output_port_one_deemph_o(d1),
    .stat_pin_o(spo), .stat_pin_oe_n_o(oe_n));
  eomctl_pullup u_eomctl_pullup (.oe_n_i(oe_n), .pin_o(pin));
  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // strobes are set at a falling edge so the rising edge between takes them
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(2);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic t_strap;
    chk({2'h0, s0, d1}, 8'h00);
    chk({4'h0, e0, c0, e1, c1}, 8'h0f);
    rreg(A_STRAPS, 8'h1e);
  endtask
  task automatic t_drive;
    wreg(A_OUTPUT_PORT_ZERO_SWING, 8'h27);
    wreg(A_OUTPUT_PORT_ONE_DEEMPH, 8'h43);
    chk({2'h0, s0, s1}, 8'h38);
    chk({2'h0, d0, d1}, 8'h03);
    rreg(A_OUTPUT_PORT_ZERO_SWING, 8'h27);
  endtask
  task automatic t_func;
    wreg(A_CTRL, 8'h03);
    chk({2'h0, e0, c0, e1, c1, cs, cv}, 8'h3f);
    rgt = 1'b0;
    wreg(A_CTRL, 8'h01);
    chk({2'h0, e0, c0, e1, c1, cs, cv}, 8'h28);
    wreg(A_CTRL, 8'h07);
    chk({2'h0, e0, c0, e1, c1, cs, cv}, 8'h00);
    wreg(A_CTRL, 8'h03);
    chk({2'h0, e0, c0, e1, c1, cs, cv}, 8'h3e);
  endtask
  // refused start below minimum rate, then a full sweep at two bits per point
  task automatic t_eom;
    rok = 1'b0;
    cyc(6);
    wreg(A_EOM_CTRL, 8'h01);
    rreg(A_EOM_STATUS, 8'h04);
    rok = 1'b1;
    wreg(A_BITS_LO, 8'h02);
    wreg(A_BITS_HI, 8'h00);
    bit_on = 1'b1;
    wreg(A_EOM_CTRL, 8'h01);
    // bounded wait: a sweep that overruns shows up as a wrong status below
    for (int i = 0; i < 12400; i++) begin
      hit = vo[0];
      cyc(1);
    end
    bit_on = 1'b0;
    rreg(A_EOM_STATUS, 8'h02);
    rreg(A_HEO, 8'h40);
    rreg(A_VEO, 8'h20);
    wreg(A_GRID_VO, 8'h01);
    rreg(A_GRID_LO, 8'h02);
    chk({2'h0, ph}, 8'h00);
  endtask
  // lock mode first, then a lock event left out of the mask and a masked loss event
  task automatic t_pin;
    lock = 1'b1;
    cyc(6);
    chk({7'h0, pin}, 8'h00);
    wreg(A_INT_MASK, 8'h01);
    wreg(A_CTRL, 8'h10);
    chk({7'h0, pin}, 8'h01);
    los0 = 1'b1;
    cyc(6);
    chk({7'h0, pin}, 8'h00);
    rreg(A_INT_STATUS, 8'h21);
    cyc(2);
    chk({7'h0, pin}, 8'h01);
    rreg(8'h7f, 8'h00);
    wreg(A_CTRL, 8'h08);
    chk({7'h0, pin}, 8'h01);
    cd = 1'b1;
    cyc(6);
    chk({7'h0, pin}, 8'h00);
    chk({7'h0, spo}, 8'h00);
  endtask
  initial begin
    cyc(12);
    arst_n_i = 1'b1;
    cyc(10);
    t_strap();
    t_drive();
    t_func();
    t_eom();
    t_pin();
    wrap_up();
  end
endmodule

/* rtl/eomctl_grid_mem.sv */
// hit-count store for the 64 x 64 eye grid
// assumes one writer and one reader, both on clk_i
`timescale 1ns/1ps
module eomctl_grid_mem #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  input  wire logic          clk_i,    // block clock
  input  wire logic          arst_n_i, // async reset, active low
  input  wire logic          ce_i,     // clock enable
  input  wire logic          we_i,     // write strobe
  input  wire logic [AW-1:0] waddr_i,  // write address
  input  wire logic [DW-1:0] wdata_i,  // write data
  input  wire logic [AW-1:0] raddr_i,  // read address
  output logic      [DW-1:0] rdata_o   // registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // array carries no reset so it maps onto ram
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read data leaves through a register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* rtl/eomctl_pkg.sv */
// constants, field layout and types for the eye monitor / output / status control block
// assumes an 8-bit register port supplied by the serial control front end
package eomctl_pkg;

  // ******************************************************
  // register offsets
  // ******************************************************
  localparam logic [7:0] A_CTRL        = 8'h10;
  localparam logic [7:0] A_INT_MASK    = 8'h11;
  localparam logic [7:0] A_INT_STATUS  = 8'h12;
  localparam logic [7:0] A_HEO_THR     = 8'h13;
  localparam logic [7:0] A_VEO_THR     = 8'h14;
  localparam logic [7:0] A_EOM_CTRL    = 8'h15;
  localparam logic [7:0] A_EOM_STATUS  = 8'h16;
  localparam logic [7:0] A_BITS_LO     = 8'h17;
  localparam logic [7:0] A_BITS_HI     = 8'h18;
  localparam logic [7:0] A_HEO         = 8'h19;
  localparam logic [7:0] A_VEO         = 8'h1a;
  localparam logic [7:0] A_GRID_PH     = 8'h1b;
  localparam logic [7:0] A_GRID_VO     = 8'h1c;
  localparam logic [7:0] A_GRID_LO     = 8'h1d;
  localparam logic [7:0] A_GRID_HI     = 8'h1e;
  localparam logic [7:0] A_STRAPS      = 8'h1f;
  localparam logic [7:0] A_OUTPUT_PORT_ZERO_SWING  = 8'h30;
  localparam logic [7:0] A_OUTPUT_PORT_ZERO_DEEMPH = 8'h31;
  localparam logic [7:0] A_OUTPUT_PORT_ONE_SWING  = 8'h32;
  localparam logic [7:0] A_OUTPUT_PORT_ONE_DEEMPH = 8'h33;

  // ******************************************************
  // field positions and reset values
  // ******************************************************
  localparam int SW_OVR     = 5;   // swing override bit
  localparam int DE_OVR     = 6;   // de-emphasis override bit
  localparam int CTRL_FOVR  = 0;   // output function override
  localparam int CTRL_FLVL  = 1;   // [2:1] function level when overridden
  localparam int CTRL_PMODE = 3;   // [4:3] status pin mode
  localparam int CTRL_CDSEL = 5;   // carrier detect input select
  localparam int EOM_START  = 0;
  localparam int NUM_INT    = 7;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [7:0]  DRV_RST   = 8'h00;
  localparam logic [7:0]  THR_RST   = 8'h10;
  localparam logic [15:0] BITS_RST  = 16'h0100;

  // ******************************************************
  // eye grid and drive codes
  // ******************************************************
  localparam logic [5:0] GRID_LAST = 6'h3f;  // 64 steps per axis
  localparam logic [5:0] GRID_MID  = 6'h20;  // 0 V row / mid-UI column
  localparam logic [2:0] DRV_H = 3'h0;
  localparam logic [2:0] DRV_F = 3'h2;
  localparam logic [2:0] DRV_R = 3'h3;
  localparam logic [2:0] DRV_L = 3'h5;
  localparam logic [2:0] SETTLE_CYC = 3'h4;  // sync pipe plus agree stage fill before capture

  typedef enum logic [1:0] {LVL_L, LVL_R, LVL_F, LVL_H} eomctl_lvl_t;
  typedef enum logic [1:0] {PIN_LOCK, PIN_CD, PIN_INT, PIN_RSVD} eomctl_pin_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STORE, ST_DONE} eomctl_state_t;

endpackage

/* rtl/eomctl_top.sv */
// eye monitor sequencer, output function / drive selection and status pin control
// assumes strap comparators, carrier/lock/loss flags and rate flags arrive asynchronously,
// eye sampler bit/hit strobes arrive on clk_i, registers written through an 8-bit port
// Functional notes
// (RULE1) eye captures valid only at >= 2.97 Gbps
// (RULE2) sweep 64 phases by 64 voltages, count hits
// (RULE3) bits observed per grid point is programmable
// (RULE4) report width at 0 V, height mid-UI
// (RULE5) output function from strap unless register override
// (RULE6) H raw, F recovered, L equalized data
// (RULE7) R: output_port_zero data, output_port_one recovered clock
// (RULE8) host avoids clock output at 10 GbE
// (RULE9) drive from strap, per-output register override
// (RULE10) override bit 5/6, level bits 2:0
// (RULE11) strap H F R L give 0 2 3 5
// (RULE12) register codes reach up to 7
// (RULE13) open-drain status pin low on lock
// (RULE14) register redirects pin to carrier or interrupt
// (RULE15) carrier mode: selected input after adaptation
// (RULE16) interrupt mode: masked sources pull pin low
// (RULE17) loss on each input, two masks each
// (RULE18) eye below threshold after lock, one mask
// (RULE19) lock event, two masks
// (RULE20) sticky flags cleared by status read
// (RULE21) four-level strap decoded from three thresholds
// (RULE22) pin is OR of masked flags; set wins
// (RULE23) straps sampled once; overrides next cycle
`timescale 1ns/1ps
module eomctl_top
  import eomctl_pkg::*;
#(
  parameter int HW = 16  // hit and bit counter width
) (
  input  wire logic       clk_i,            // 25 MHz block clock
  input  wire logic       arst_n_i,         // async reset, active low
  input  wire logic       ce_i,             // clock enable, freezes all state
  input  wire logic [2:0] func_strap_i,     // function strap comparators {0.8,0.5,0.2}
  input  wire logic [2:0] drv_strap_i,      // drive strap comparators {0.8,0.5,0.2}
  input  wire logic       cdr_lock_i,       // reclocker locked
  input  wire logic       cd0_i,            // carrier seen on input 0
  input  wire logic       cd1_i,            // carrier seen on input 1
  input  wire logic       adapt_done_i,     // adaptation finished
  input  wire logic       los0_i,           // loss of signal, input 0
  input  wire logic       los1_i,           // loss of signal, input 1
  input  wire logic       rate_eom_ok_i,    // rate at or above 2.97 Gbps
  input  wire logic       rate_gt_3g_i,     // rate above 3 Gbps
  input  wire logic       eom_bit_i,        // one bit observed by eye sampler
  input  wire logic       eom_hit_i,        // that bit was a hit
  input  wire logic [7:0] reg_addr_i,       // register address
  input  wire logic       reg_wr_i,         // register write strobe
  input  wire logic       reg_rd_i,         // register read strobe
  input  wire logic [7:0] reg_wdata_i,      // register write data
  output logic      [7:0] reg_rdata_o,      // read data, one cycle after strobe
  output logic      [5:0] eom_phase_o,      // sampler phase offset step
  output logic      [5:0] eom_volt_o,       // sampler voltage offset step
  output logic            output_port_zero_eq_en_o,     // output_port_zero equalizer in path
  output logic            output_port_zero_cdr_en_o,    // output_port_zero reclocker in path
  output logic            output_port_one_eq_en_o,     // output_port_one equalizer in path
  output logic            output_port_one_cdr_en_o,    // output_port_one reclocker in path
  output logic            output_port_one_clk_sel_o,   // output_port_one carries recovered clock
  output logic            output_port_one_clk_div_o,   // output_port_one clock at 297 MHz
  output logic      [2:0] output_port_zero_swing_o,     // output_port_zero swing code
  output logic      [2:0] output_port_zero_deemph_o,    // output_port_zero de-emphasis code
  output logic      [2:0] output_port_one_swing_o,     // output_port_one swing code
  output logic      [2:0] output_port_one_deemph_o,    // output_port_one de-emphasis code
  output logic            stat_pin_o,       // status pin drive value, always 0
  output logic            stat_pin_oe_n_o   // low while pin pulled low
);
  // ******************************************************
  // input synchronisers
  // ******************************************************
  localparam int NS = 14;
  logic [NS-1:0] raw_in, s1, s2, s3, clean;
  assign raw_in = {rate_gt_3g_i, rate_eom_ok_i, los1_i, los0_i, adapt_done_i, cd1_i, cd0_i,
                    cdr_lock_i, drv_strap_i, func_strap_i};

  // three stages per pin; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          s1[g]    <= 1'b0;
          s2[g]    <= 1'b0;
          s3[g]    <= 1'b0;
          clean[g] <= 1'b0;
        end else if (ce_i) begin
          s1[g] <= raw_in[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            clean[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  logic lock_s, cd0_s, cd1_s, adapt_s, los0_s, los1_s, rate_ok_s, rate_hi_s;
  assign {rate_hi_s, rate_ok_s, los1_s, los0_s, adapt_s, cd1_s, cd0_s, lock_s} = clean[13:6];

  // ******************************************************
  // strap capture
  // ******************************************************
  function automatic eomctl_lvl_t lvl_of(input logic [2:0] t);
    if (t[2]) return LVL_H;            // [RULE21]
    else if (t[1]) return LVL_F;       // middle threshold splits upper from lower pair
    else if (t[0]) return LVL_R;
    else return LVL_L;
  endfunction

  logic [2:0]  settle;
  logic        strap_taken;
  eomctl_lvl_t func_strap, drv_strap;

  // straps are latched once after the sync pipe fills; later pin moves are ignored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle      <= 3'h0;
      strap_taken <= 1'b0;
      func_strap  <= LVL_L;
      drv_strap   <= LVL_L;
    end else if (ce_i && !strap_taken) begin
      if (settle == SETTLE_CYC) begin  // [RULE23]
        func_strap  <= lvl_of(clean[2:0]);
        drv_strap   <= lvl_of(clean[5:3]);
        strap_taken <= 1'b1;
      end else begin
        settle <= settle + 3'h1;
      end
    end
  end

  // ******************************************************
  // registers
  // ******************************************************
  logic [7:0]  ctrl, int_mask, heo_thr, veo_thr, sw0, de0, sw1, de1;
  logic [15:0] bits_pt;
  logic [5:0]  grid_ph, grid_vo;
  logic        wr, rd_int, eom_go;
  assign wr     = ce_i && reg_wr_i;
  assign rd_int = ce_i && reg_rd_i && (reg_addr_i == A_INT_STATUS);
  assign eom_go = wr && (reg_addr_i == A_EOM_CTRL) && reg_wdata_i[EOM_START];

  // write decode; full 3-bit codes 0..7 are stored as written
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl     <= CTRL_RST;
      int_mask <= MASK_RST;
      heo_thr  <= THR_RST;
      veo_thr  <= THR_RST;
      bits_pt  <= BITS_RST;
      grid_ph  <= 6'h00;
      grid_vo  <= 6'h00;
      sw0      <= DRV_RST;
      de0      <= DRV_RST;
      sw1      <= DRV_RST;
      de1      <= DRV_RST;
    end else if (wr) begin
      unique case (reg_addr_i)
        A_CTRL:        ctrl          <= reg_wdata_i;
        A_INT_MASK:    int_mask      <= reg_wdata_i;
        A_HEO_THR:     heo_thr       <= reg_wdata_i;
        A_VEO_THR:     veo_thr       <= reg_wdata_i;
        A_BITS_LO:     bits_pt[7:0]  <= reg_wdata_i;  // [RULE3]
        A_BITS_HI:     bits_pt[15:8] <= reg_wdata_i;
        A_GRID_PH:     grid_ph       <= reg_wdata_i[5:0];
        A_GRID_VO:     grid_vo       <= reg_wdata_i[5:0];
        A_OUTPUT_PORT_ZERO_SWING:  sw0           <= reg_wdata_i;  // [RULE12]
        A_OUTPUT_PORT_ZERO_DEEMPH: de0           <= reg_wdata_i;
        A_OUTPUT_PORT_ONE_SWING:  sw1           <= reg_wdata_i;
        A_OUTPUT_PORT_ONE_DEEMPH: de1           <= reg_wdata_i;
        default:       ;
      endcase
    end
  end

  // ******************************************************
  // eye opening monitor sequencer
  // ******************************************************
  eomctl_state_t state;
  logic [HW-1:0] bit_cnt, hit_cnt;
  logic [6:0]    horizontal_eye_width, vertical_eye_height;
  logic          eom_done, eom_bad, eye_low_ev;
  logic [15:0]   grid_rdata;
  logic          last_bit, last_pt;
  assign last_bit = eom_bit_i && (bit_cnt == HW'(bits_pt - 16'h1));
  assign last_pt  = (eom_phase_o == GRID_LAST) && (eom_volt_o == GRID_LAST);

  // voltage sweeps inside phase; width counted on 0 V row, height on mid-UI column
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state       <= ST_IDLE;
      bit_cnt     <= '0;
      hit_cnt     <= '0;
      eom_phase_o <= 6'h00;
      eom_volt_o  <= 6'h00;
      horizontal_eye_width         <= 7'h00;
      vertical_eye_height         <= 7'h00;
      eom_done    <= 1'b0;
      eom_bad     <= 1'b0;
      eye_low_ev  <= 1'b0;
    end else if (ce_i) begin
      eye_low_ev <= 1'b0;
      unique case (state)
        ST_IDLE: if (eom_go) begin
          eom_done <= 1'b0;
          eom_bad  <= !rate_ok_s;                         // [RULE1]
          if (rate_ok_s) begin
            state       <= ST_RUN;
            eom_phase_o <= 6'h00;
            eom_volt_o  <= 6'h00;
            bit_cnt     <= '0;
            hit_cnt     <= '0;
            horizontal_eye_width         <= 7'h00;
            vertical_eye_height         <= 7'h00;
          end
        end
        ST_RUN: begin
          if (!rate_ok_s) begin
            eom_bad <= 1'b1;                              // [RULE1]
            state   <= ST_IDLE;
          end else if (eom_bit_i) begin
            bit_cnt <= bit_cnt + HW'(1);
            hit_cnt <= hit_cnt + HW'(eom_hit_i);          // [RULE2]
            if (last_bit) begin
              state <= ST_STORE;                          // [RULE3]
            end
          end
        end
        ST_STORE: begin
          if (eom_volt_o == GRID_MID && hit_cnt == '0) begin
            horizontal_eye_width <= horizontal_eye_width + 7'h01;                           // [RULE4]
          end
          if (eom_phase_o == GRID_MID && hit_cnt == '0) begin
            vertical_eye_height <= vertical_eye_height + 7'h01;                           // [RULE4]
          end
          bit_cnt    <= '0;
          hit_cnt    <= '0;
          eom_volt_o <= eom_volt_o + 6'h01;               // [RULE2]
          if (eom_volt_o == GRID_LAST) begin
            eom_phase_o <= eom_phase_o + 6'h01;
          end
          state <= last_pt ? ST_DONE : ST_RUN;
        end
        ST_DONE: begin
          eom_done   <= 1'b1;
          eye_low_ev <= lock_s && ((horizontal_eye_width < heo_thr[6:0]) || (vertical_eye_height < veo_thr[6:0]));  // [RULE18]
          state      <= ST_IDLE;
        end
      endcase
    end
  end

  eomctl_grid_mem #(
    .AW (12),
    .DW (16)
  ) u_grid (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .we_i     (state == ST_STORE),
    .waddr_i  ({eom_phase_o, eom_volt_o}),
    .wdata_i  (16'(hit_cnt)),
    .raddr_i  ({grid_ph, grid_vo}),
    .rdata_o  (grid_rdata)
  );

  // ******************************************************
  // interrupt sources and sticky flags
  // ******************************************************
  logic                lock_q, los0_q, los1_q;
  logic [NUM_INT-1:0]  int_ev, int_flags;
  assign int_ev = {!lock_s && lock_q, lock_s && !lock_q,  // [RULE19]
                   eye_low_ev,                            // [RULE18]
                   !los1_s && los1_q, los1_s && !los1_q,  // [RULE17]
                   !los0_s && los0_q, los0_s && !los0_q};

  // a source firing during the status read is kept: set beats clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_q    <= 1'b0;
      los0_q    <= 1'b0;
      los1_q    <= 1'b0;
      int_flags <= '0;
    end else if (ce_i) begin
      lock_q    <= lock_s;
      los0_q    <= los0_s;
      los1_q    <= los1_s;
      int_flags <= (rd_int ? '0 : int_flags) | int_ev;   // [RULE20] [RULE22]
    end
  end

  // ******************************************************
  // register read
  // ******************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      unique case (reg_addr_i)
        A_CTRL:        reg_rdata_o <= ctrl;
        A_INT_MASK:    reg_rdata_o <= int_mask;
        A_INT_STATUS:  reg_rdata_o <= {1'b0, int_flags};
        A_HEO_THR:     reg_rdata_o <= heo_thr;
        A_VEO_THR:     reg_rdata_o <= veo_thr;
        A_EOM_STATUS:  reg_rdata_o <= {5'h00, eom_bad, eom_done, state != ST_IDLE};
        A_BITS_LO:     reg_rdata_o <= bits_pt[7:0];
        A_BITS_HI:     reg_rdata_o <= bits_pt[15:8];
        A_HEO:         reg_rdata_o <= {1'b0, horizontal_eye_width};
        A_VEO:         reg_rdata_o <= {1'b0, vertical_eye_height};
        A_GRID_PH:     reg_rdata_o <= {2'h0, grid_ph};
        A_GRID_VO:     reg_rdata_o <= {2'h0, grid_vo};
        A_GRID_LO:     reg_rdata_o <= grid_rdata[7:0];
        A_GRID_HI:     reg_rdata_o <= grid_rdata[15:8];
        A_STRAPS:      reg_rdata_o <= {3'h0, strap_taken, drv_strap, func_strap};
        A_OUTPUT_PORT_ZERO_SWING:  reg_rdata_o <= sw0;
        A_OUTPUT_PORT_ZERO_DEEMPH: reg_rdata_o <= de0;
        A_OUTPUT_PORT_ONE_SWING:  reg_rdata_o <= sw1;
        A_OUTPUT_PORT_ONE_DEEMPH: reg_rdata_o <= de1;
        default:       reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ******************************************************
  // output function, drive and status pin
  // ******************************************************
  eomctl_lvl_t func_lvl;
  eomctl_pin_t pin_mode;
  logic [2:0]  drv_code;
  logic        pin_assert;
  assign func_lvl = ctrl[CTRL_FOVR] ? eomctl_lvl_t'(ctrl[CTRL_FLVL +: 2]) : func_strap;  // [RULE5]
  assign pin_mode = eomctl_pin_t'(ctrl[CTRL_PMODE +: 2]);
  always_comb begin
    unique case (drv_strap)                              // [RULE11]
      LVL_H: drv_code = DRV_H;
      LVL_F: drv_code = DRV_F;
      LVL_R: drv_code = DRV_R;
      LVL_L: drv_code = DRV_L;
    endcase
  end
  always_comb begin
    unique case (pin_mode)                               // [RULE14]
      PIN_CD:  pin_assert = adapt_s && (ctrl[CTRL_CDSEL] ? cd1_s : cd0_s);  // [RULE15]
      PIN_INT: pin_assert = |(int_flags & int_mask[NUM_INT-1:0]);          // [RULE16] [RULE22]
      default: pin_assert = lock_s;                      // [RULE13]
    endcase
  end

  // outputs follow the registered selections one edge later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {output_port_zero_eq_en_o, output_port_zero_cdr_en_o, output_port_one_eq_en_o, output_port_one_cdr_en_o} <= 4'h0;
      output_port_one_clk_sel_o  <= 1'b0;
      output_port_one_clk_div_o  <= 1'b0;
      output_port_zero_swing_o    <= 3'h0;
      output_port_zero_deemph_o   <= 3'h0;
      output_port_one_swing_o    <= 3'h0;
      output_port_one_deemph_o   <= 3'h0;
      stat_pin_o      <= 1'b0;
      stat_pin_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      // recovered clock is only meaningful at video rates; the host avoids it at 10 GbE
      output_port_zero_eq_en_o   <= func_lvl != LVL_H;                               // [RULE6]
      output_port_zero_cdr_en_o  <= func_lvl == LVL_F || func_lvl == LVL_R;          // [RULE6]
      output_port_one_eq_en_o   <= func_lvl != LVL_H;
      output_port_one_cdr_en_o  <= func_lvl == LVL_F || func_lvl == LVL_R;
      output_port_one_clk_sel_o <= func_lvl == LVL_R;                               // [RULE7]
      output_port_one_clk_div_o <= func_lvl == LVL_R && rate_hi_s;                  // [RULE7]
      output_port_zero_swing_o   <= sw0[SW_OVR] ? sw0[2:0] : drv_code;               // [RULE9] [RULE10]
      output_port_zero_deemph_o  <= de0[DE_OVR] ? de0[2:0] : drv_code;
      output_port_one_swing_o   <= sw1[SW_OVR] ? sw1[2:0] : drv_code;
      output_port_one_deemph_o  <= de1[DE_OVR] ? de1[2:0] : drv_code;
      stat_pin_o      <= 1'b0;
      stat_pin_oe_n_o <= !pin_assert;                                    // open drain
    end
  end

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_last_store;
    ce_i && state == ST_STORE && last_pt;
  endsequence
  sequence s_done_flag;
    (ce_i && state == ST_DONE) ##1 eom_done;
  endsequence

  AST_GRID_END: assert property (s_last_store |=> s_done_flag)  // [RULE2]
    else $error("grid sweep did not finish after last point");
  AST_RATE_GATE: assert property (eom_go && state == ST_IDLE && !rate_ok_s |=>
      state == ST_IDLE && eom_bad)  // [RULE1]
    else $error("capture started below minimum rate");
  AST_BITS_PT: assert property (ce_i && state == ST_RUN && rate_ok_s && last_bit |=>
      state == ST_STORE && bit_cnt == HW'(bits_pt))  // [RULE3]
    else $error("point did not close at programmed bit count");
  AST_SWING_STRAP: assert property (ce_i && !sw0[SW_OVR] && drv_strap == LVL_L |=>
      output_port_zero_swing_o == 3'h5)  // [RULE11]
    else $error("strap L swing code wrong");
  AST_DEEMPH_OVR: assert property (ce_i && de1[DE_OVR] |=> output_port_one_deemph_o == $past(de1[2:0]))  // [RULE10]
    else $error("de-emphasis override not applied");
  AST_FUNC_R: assert property (ce_i && func_lvl == LVL_R |=>
      output_port_one_clk_sel_o && output_port_zero_cdr_en_o && output_port_one_clk_div_o == $past(rate_hi_s))  // [RULE7]
    else $error("level R output function wrong");
  AST_STICKY: assert property (ce_i && !rd_int |=>
      (int_flags & $past(int_flags)) == $past(int_flags))  // [RULE20]
    else $error("interrupt flag dropped without status read");
  AST_SET_WINS: assert property (rd_int |=> int_flags == $past(int_ev))  // [RULE22]
    else $error("event lost during status read");
  AST_INT_PIN: assert property (ce_i && pin_mode == PIN_INT && |(int_flags & int_mask[6:0])
      |=> !stat_pin_oe_n_o)  // [RULE16]
    else $error("masked interrupt did not pull pin low");
  AST_LOCK_PIN: assert property (ce_i && ctrl[4:3] == 2'h0 |=> stat_pin_oe_n_o == !$past(lock_s))  // [RULE13]
    else $error("lock mode pin mismatch");
  AST_STRAP_ONCE: assert property (ce_i && strap_taken |=> $stable(func_strap) && $stable(drv_strap))  // [RULE23]
    else $error("strap level changed after capture");
endmodule
